// ===== power_ctrl_model.sv
// power controller model driving the core power and state-lost pins
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_model (
   input  wire logic powerOn,
   input  wire logic loseState,
   output logic      corePowerPin,
   output logic      stateLostPin
);
   assign corePowerPin = powerOn;
   // the loss report is a level the controller may still hold as power returns
   assign stateLostPin = loseState;
endmodule // power_ctrl_model
`default_nettype wire

// ===== sync_two_flop.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_type;

   sync_state_type s;
   sync_state_type next_s;

   always_comb begin
      next_s        = s;
      next_s.stage1 = asyncIn;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign syncOut = s.stage2;
endmodule // sync_two_flop
`default_nettype wire

// ===== trace_power_status_and_id_regs.sv
// power-down status flag and low identification registers of the trace unit
`timescale 1ns/1ps
`default_nettype none
module trace_power_status_and_id_regs #(
   parameter logic [11:0] PART_NUMBER = trace_pwr_pkg::DEF_PART_NUMBER,
   parameter logic [3:0]  DESIGNER_LO = trace_pwr_pkg::DEF_DESIGNER_LO
) (
   input  wire logic                             clk,
   input  wire logic                             arst_n,
   input  wire logic                             corePowerPin,
   input  wire logic                             stateLostPin,
   input  wire logic                             softwareLockLocked,
   input  wire logic                             readEn,
   input  wire logic                             readMemMapped,
   input  wire logic [trace_pwr_pkg::IDX_W-1:0]  readAddr,
   output logic      [trace_pwr_pkg::DATA_W-1:0] readData,
   output logic                                  readValid,
   output logic                                  readError,
   output logic                                  powerStatus,
   output logic                                  stateLostFlag,
   output logic                                  regsAccessible,
   output logic                                  stateValid
);
   typedef struct packed {
      logic                             flag;
      logic                             poweredPrev;
      logic [trace_pwr_pkg::DATA_W-1:0] rdData;
      logic                             rdValid;
      logic                             rdError;
   } regs_state_type;

   regs_state_type s;
   regs_state_type next_s;

   logic [trace_pwr_pkg::SYNC_W-1:0] pinSync;
   logic                             powered;
   logic                             lostInd;
   logic                             powerReturn;
   logic                             setFlag;
   logic                             clearFlag;
   logic [trace_pwr_pkg::DATA_W-1:0] pdsrWord;
   logic [trace_pwr_pkg::DATA_W-1:0] pid0Word;
   logic [trace_pwr_pkg::DATA_W-1:0] pid1Word;

   // power controller pins arrive from another domain
   sync_two_flop #(
      .WIDTH (trace_pwr_pkg::SYNC_W)
   ) u_pin_sync (
      .clk     (clk),
      .arst_n  (arst_n),
      .asyncIn ({stateLostPin, corePowerPin}),
      .syncOut (pinSync)
   );

   assign powered     = pinSync[trace_pwr_pkg::SYNC_POWER];
   assign lostInd     = pinSync[trace_pwr_pkg::SYNC_LOST];
   assign powerReturn = powered && !s.poweredPrev;

   // loss is only believed while down or at the return edge; a retained domain never raises it
   assign setFlag   = lostInd && (!powered || powerReturn);
   // a locked memory-mapped read or a powered-down domain leaves the flag alone
   assign clearFlag = readEn && (readAddr == trace_pwr_pkg::IDX_PDSR) && powered
                      && !(readMemMapped && softwareLockLocked);

   always_comb begin
      pdsrWord                                 = '0;
      pdsrWord[trace_pwr_pkg::PDSR_POWER_BIT]  = powered;
      pdsrWord[trace_pwr_pkg::PDSR_STICKY_BIT] = s.flag;
      pid0Word = '0;
      pid0Word[trace_pwr_pkg::ID_BYTE_W-1:0] = PART_NUMBER[trace_pwr_pkg::ID_BYTE_W-1:0];
      pid1Word = '0;
      pid1Word[trace_pwr_pkg::ID_BYTE_W-1:0] =
         {DESIGNER_LO, PART_NUMBER[trace_pwr_pkg::PART_W-1:trace_pwr_pkg::ID_BYTE_W]};
   end

   always_comb begin
      next_s             = s;
      next_s.poweredPrev = powered;
      next_s.rdValid     = 1'b0;
      next_s.rdError     = 1'b0;
      // no loss seen: the flag simply holds across the outage and is valid again on return
      if (setFlag) begin
         next_s.flag = 1'b1;
      end else if (clearFlag) begin
         next_s.flag = 1'b0;
      end
      // every read arrives on the memory-mapped or debugger path flagged by readMemMapped
      if (readEn) begin
         next_s.rdValid = 1'b1;
         case (readAddr)
            trace_pwr_pkg::IDX_PDSR: next_s.rdData = pdsrWord;
            trace_pwr_pkg::IDX_PID0: next_s.rdData = pid0Word;
            trace_pwr_pkg::IDX_PID1: next_s.rdData = pid1Word;
            default: begin
               next_s.rdData  = '0;
               next_s.rdError = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s      <= '0;
         s.flag <= trace_pwr_pkg::STICKY_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign readData       = s.rdData;
   assign readValid      = s.rdValid;
   assign readError      = s.rdError;
   assign powerStatus    = powered;
   assign stateLostFlag  = s.flag;
   // with loss unknown while down the flag may still read 0
   assign regsAccessible = powered;
   assign stateValid     = powered && !s.flag;

   property p_reset_sets;
      @(posedge clk) $rose(arst_n) |-> stateLostFlag;
   endproperty
   a_reset_sets: assert property (p_reset_sets) else $error("flag not set by reset");

   property p_read_clears;
      @(posedge clk) disable iff (!arst_n)
         readEn && readAddr == trace_pwr_pkg::IDX_PDSR && powered && !(readMemMapped && softwareLockLocked)
         && !setFlag |=> !stateLostFlag;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status read did not clear flag");

   property p_locked_keeps;
      @(posedge clk) disable iff (!arst_n)
         readEn && readAddr == trace_pwr_pkg::IDX_PDSR && (!powered || (readMemMapped && softwareLockLocked))
         |=> stateLostFlag == ($past(stateLostFlag) || $past(setFlag));
   endproperty
   a_locked_keeps: assert property (p_locked_keeps) else $error("flag changed on a blocked read");

   property p_lost_on_return;
      @(posedge clk) disable iff (!arst_n)
         $rose(powerStatus) && lostInd |=> stateLostFlag && powerStatus;
   endproperty
   a_lost_on_return: assert property (p_lost_on_return) else $error("lost state not flagged on return");

   property p_retained_restores;
      @(posedge clk) disable iff (!arst_n)
         !powerStatus && !lostInd ##1 !lostInd && powerStatus && !readEn |=> stateLostFlag == $past(stateLostFlag, 2);
   endproperty
   a_retained_restores: assert property (p_retained_restores) else $error("flag not restored");

   property p_lost_while_down;
      @(posedge clk) disable iff (!arst_n)
         !powerStatus && lostInd |=> stateLostFlag;
   endproperty
   a_lost_while_down: assert property (p_lost_while_down) else $error("flag not raised while down");

   property p_down_inaccessible;
      @(posedge clk) disable iff (!arst_n)
         !powerStatus |-> !regsAccessible && !stateValid;
   endproperty
   a_down_inaccessible: assert property (p_down_inaccessible) else $error("unpowered domain accessible");

   property p_powered_valid;
      @(posedge clk) disable iff (!arst_n)
         powerStatus |-> regsAccessible && (stateValid != stateLostFlag);
   endproperty
   a_powered_valid: assert property (p_powered_valid) else $error("powered status wrong");

   property p_id_upper_zero;
      @(posedge clk) disable iff (!arst_n)
         readEn && readAddr != trace_pwr_pkg::IDX_PDSR
         |=> readValid && readData[trace_pwr_pkg::DATA_W-1:trace_pwr_pkg::ID_BYTE_W] == '0;
   endproperty
   a_id_upper_zero: assert property (p_id_upper_zero) else $error("id upper bits not zero");

   property p_id0_value;
      @(posedge clk) disable iff (!arst_n)
         readEn && readAddr == trace_pwr_pkg::IDX_PID0 |=> readValid && !readError
         && readData[trace_pwr_pkg::ID_BYTE_W-1:0] == PART_NUMBER[trace_pwr_pkg::ID_BYTE_W-1:0];
   endproperty
   a_id0_value: assert property (p_id0_value) else $error("part number low byte wrong");

   property p_id1_value;
      @(posedge clk) disable iff (!arst_n)
         readEn && readAddr == trace_pwr_pkg::IDX_PID1 |=> readValid
         && readData[trace_pwr_pkg::PART_HIGH_W-1:0] == PART_NUMBER[trace_pwr_pkg::PART_W-1:trace_pwr_pkg::ID_BYTE_W]
         && readData[trace_pwr_pkg::ID_BYTE_W-1:trace_pwr_pkg::PART_HIGH_W] == DESIGNER_LO;
   endproperty
   a_id1_value: assert property (p_id1_value) else $error("second id word wrong");

   property p_unmapped_error;
      @(posedge clk) disable iff (!arst_n)
         readEn && readAddr != trace_pwr_pkg::IDX_PDSR && readAddr != trace_pwr_pkg::IDX_PID0
         && readAddr != trace_pwr_pkg::IDX_PID1 |=> readValid && readError && readData == '0;
   endproperty
   a_unmapped_error: assert property (p_unmapped_error) else $error("unmapped index not refused");

   property p_answer_only_reads;
      @(posedge clk) disable iff (!arst_n)
         !readEn |=> !readValid && !readError && $stable(readData);
   endproperty
   a_answer_only_reads: assert property (p_answer_only_reads) else $error("answer without a read");

   property p_read_answered;
      @(posedge clk) disable iff (!arst_n)
         readEn |=> readValid;
   endproperty
   a_read_answered: assert property (p_read_answered) else $error("read not answered");

   // the status word shows the flag as it was before the read clears it
   property p_status_word;
      @(posedge clk) disable iff (!arst_n)
         readEn && readAddr == trace_pwr_pkg::IDX_PDSR |=> readValid && !readError
         && readData[trace_pwr_pkg::PDSR_POWER_BIT] == $past(powerStatus)
         && readData[trace_pwr_pkg::PDSR_STICKY_BIT] == $past(stateLostFlag);
   endproperty
   a_status_word: assert property (p_status_word) else $error("status word fields wrong");

   // only a status read may drop the flag, and never against a loss in the same cycle
   property p_flag_falls_on_read;
      @(posedge clk) disable iff (!arst_n)
         $fell(stateLostFlag) |-> $past(clearFlag) && !$past(setFlag);
   endproperty
   a_flag_falls_on_read: assert property (p_flag_falls_on_read) else $error("flag dropped without a read");

   property p_flag_rises_on_loss;
      @(posedge clk) disable iff (!arst_n)
         $rose(stateLostFlag) |-> $past(setFlag);
   endproperty
   a_flag_rises_on_loss: assert property (p_flag_rises_on_loss) else $error("flag raised without a loss");

   // a loss level still high while powered is stale news from the last outage
   property p_powered_ignores_pin;
      @(posedge clk) disable iff (!arst_n)
         powerStatus && !$rose(powerStatus) |=> !$rose(stateLostFlag);
   endproperty
   a_powered_ignores_pin: assert property (p_powered_ignores_pin) else $error("flag raised while powered");
endmodule // trace_power_status_and_id_regs
`default_nettype wire

// ===== trace_power_status_and_id_regs_test.sv
// self-checking testbench for the power status and identification registers
`timescale 1ns/1ps
`default_nettype none
module trace_power_status_and_id_regs_test;
   logic        clk;
   logic        arstN;
   logic        powerOn;
   logic        loseState;
   logic        corePowerPin;
   logic        stateLostPin;
   logic        softwareLockLocked;
   logic        readEn;
   logic        readMemMapped;
   logic [3:0]  readAddr;
   logic [31:0] readData;
   logic        readValid;
   logic        readError;
   logic        powerStatus;
   logic        stateLostFlag;
   logic        regsAccessible;
   logic        stateValid;
   int          fails;
   int          checksDone;
   logic [7:0]  idLow;

   power_ctrl_model u_pwr (.powerOn(powerOn), .loseState(loseState), .corePowerPin(corePowerPin),
                           .stateLostPin(stateLostPin));

   trace_power_status_and_id_regs u_dut (.clk(clk), .arst_n(arstN), .corePowerPin(corePowerPin),
      .stateLostPin(stateLostPin), .softwareLockLocked(softwareLockLocked), .readEn(readEn),
      .readMemMapped(readMemMapped), .readAddr(readAddr), .readData(readData), .readValid(readValid),
      .readError(readError), .powerStatus(powerStatus), .stateLostFlag(stateLostFlag),
      .regsAccessible(regsAccessible), .stateValid(stateValid));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle read pulse, answer looked at mid-cycle after the answering edge
   task automatic rd(input logic [3:0] addr, input logic mm, input logic [31:0] exp, input logic err);
      @(negedge clk);
      readEn = 1'b1;
      readAddr = addr;
      readMemMapped = mm;
      @(negedge clk);
      readEn = 1'b0;
      check({31'h0, readValid}, 32'h1);
      check({31'h0, readError}, {31'h0, err});
      check(readData, exp);
   endtask

   // synchroniser needs two edges and the flag one more, so four cycles settle it
   task automatic pwr(input logic on, input logic lose);
      @(negedge clk);
      powerOn = on;
      loseState = lose;
      repeat (4) @(negedge clk);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // the tests take about 125 cycles, so 5000 is a generous ceiling
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      tally_and_finish();
   end

   initial begin
      arstN = 1'b0;
      powerOn = 1'b0;
      loseState = 1'b0;
      softwareLockLocked = 1'b1;
      readEn = 1'b0;
      readMemMapped = 1'b0;
      readAddr = 4'h0;
      fails = 0;
      checksDone = 0;
      repeat (6) @(negedge clk);
      arstN = 1'b1;
      check({31'h0, stateLostFlag}, 32'h1);
      check({31'h0, stateValid}, 32'h0);
      rd(4'h1, 1'b1, {24'h0, trace_pwr_pkg::DEF_PART_NUMBER[7:0]}, 1'b0);
      idLow = readData[7:0];
      rd(4'h2, 1'b0, {24'h0, trace_pwr_pkg::DEF_DESIGNER_LO, trace_pwr_pkg::DEF_PART_NUMBER[11:8]}, 1'b0);
      // software view: the low bytes joined give designer bits and the whole part number
      check({16'h0, readData[7:0], idLow},
            {16'h0, trace_pwr_pkg::DEF_DESIGNER_LO, trace_pwr_pkg::DEF_PART_NUMBER});
      for (int a = 3; a < 16; a++) begin
         rd(a[3:0], 1'b1, 32'h0, 1'b1);
      end
      rd(4'h0, 1'b0, 32'h2, 1'b0);
      rd(4'h0, 1'b0, 32'h2, 1'b0);
      pwr(1'b1, 1'b0);
      check({31'h0, regsAccessible}, 32'h1);
      check({31'h0, powerStatus}, 32'h1);
      rd(4'h0, 1'b1, 32'h3, 1'b0);
      rd(4'h0, 1'b1, 32'h3, 1'b0);
      rd(4'h0, 1'b0, 32'h3, 1'b0);
      rd(4'h0, 1'b1, 32'h1, 1'b0);
      check({31'h0, stateValid}, 32'h1);
      pwr(1'b0, 1'b0);
      check({31'h0, regsAccessible}, 32'h0);
      check({31'h0, powerStatus}, 32'h0);
      rd(4'h0, 1'b0, 32'h0, 1'b0);
      pwr(1'b1, 1'b0);
      rd(4'h0, 1'b0, 32'h1, 1'b0);
      pwr(1'b0, 1'b1);
      rd(4'h0, 1'b0, 32'h2, 1'b0);
      pwr(1'b1, 1'b0);
      rd(4'h0, 1'b1, 32'h3, 1'b0);
      pwr(1'b0, 1'b0);
      pwr(1'b1, 1'b0);
      rd(4'h0, 1'b0, 32'h3, 1'b0);
      rd(4'h0, 1'b0, 32'h1, 1'b0);
      // loss reported only as power returns, then an unlocked memory-mapped read clears it
      pwr(1'b0, 1'b0);
      pwr(1'b1, 1'b1);
      pwr(1'b1, 1'b0);
      softwareLockLocked = 1'b0;
      rd(4'h0, 1'b1, 32'h3, 1'b0);
      rd(4'h0, 1'b1, 32'h1, 1'b0);
      // second reset in mid-run, domain still powered
      arstN = 1'b0;
      @(negedge clk);
      check({31'h0, stateLostFlag}, 32'h1);
      arstN = 1'b1;
      pwr(1'b1, 1'b0);
      rd(4'h0, 1'b0, 32'h3, 1'b0);
      rd(4'h1, 1'b0, {24'h0, trace_pwr_pkg::DEF_PART_NUMBER[7:0]}, 1'b0);
      tally_and_finish();
   end
endmodule // trace_power_status_and_id_regs_test
`default_nettype wire

// ===== trace_pwr_pkg.sv
// constants for the trace unit power status and identification registers
// Behaviour
// - power 0 with flag 0 reports unpowered, registers inaccessible, state maybe invalid.
// - state kept while unpowered means the flag keeps its earlier value on power return.
// - state lost while unpowered sets the flag to 1 when power returns.
// - flag may read 0 while unpowered when loss is unknown.
// - flag is driven to 1 while unpowered once state is known lost.
// - leaving retention keeps state valid and the flag at its pre-power-down value.
// - flag 0 and power 1 report powered, accessible, state valid.
// - flag 1 and power 0 report unpowered, inaccessible, state not valid.
// - both 1 report powered and accessible, but state may be invalid.
// - identification words are 32-bit read-only, low byte only, upper bits zero.
// - identification words are read only through memory-mapped or debugger paths.
// - first identification word returns part number bits 7:0.
// - second identification word returns part number bits 11:8 in its low nibble.
// - second identification word returns designer code bits 3:0 in its upper nibble.
// - reading power-down status clears the flag unless locked memory-mapped or unpowered.
// - trace unit reset sets the flag to 1.
package trace_pwr_pkg;
   localparam int          DATA_W          = 32;
   localparam int          IDX_W           = 4;
   // register indices on the read port
   localparam logic [3:0]  IDX_PDSR        = 4'h0;
   localparam logic [3:0]  IDX_PID0        = 4'h1;
   localparam logic [3:0]  IDX_PID1        = 4'h2;
   // power-down status fields
   localparam int          PDSR_POWER_BIT  = 0;
   localparam int          PDSR_STICKY_BIT = 1;
   localparam logic        STICKY_RESET    = 1'b1;
   // identification fields
   localparam int          PART_W          = 12;
   localparam int          DES_LOW_W       = 4;
   localparam int          ID_BYTE_W       = 8;
   localparam int          PART_HIGH_W     = 4;
   // arbitrary neutral identification values
   localparam logic [11:0] DEF_PART_NUMBER = 12'h5a1;
   localparam logic [3:0]  DEF_DESIGNER_LO = 4'h6;
   localparam int          SYNC_W          = 2;
   localparam int          SYNC_POWER      = 0;
   localparam int          SYNC_LOST       = 1;
endpackage
